// ==== src/stbcd_bank.v ====
// Purpose: State tracker for one SDRAM bank.
// Assumes: Command strobes are already qualified for this bank.
// Notes: burst_len of zero means the burst runs until stopped.
`timescale 1ns/1ps
`default_nettype none
`include "stbcd_map.vh"

module stbcd_bank
(
   input wire ref_clk,
   input wire rst_n,
   input wire hold,
   input wire do_open,
   input wire do_read,
   input wire do_write,
   input wire do_auto,
   input wire do_stop,
   input wire do_close,
   input wire [3:0] burst_len,
   output reg [5:0] state_q
);

   localparam ST_IDLE = `STBCD_ST_IDLE;
   localparam ST_ACTIVE = `STBCD_ST_ACTIVE;
   localparam ST_READ = `STBCD_ST_READ;
   localparam ST_WRITE = `STBCD_ST_WRITE;
   localparam ST_RD_AUTO = `STBCD_ST_RD_AUTO;
   localparam ST_WR_AUTO = `STBCD_ST_WR_AUTO;

   reg [5:0] state_d;
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg endless_q;
   reg endless_d;
   wire open_row;

   assign open_row = (state_q != ST_IDLE);

   // ==================================================
   // Next state
   always @*
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      endless_d = endless_q;
      if (hold)
      begin
         state_d = state_q;
      end
      else if (do_close)
      begin
         state_d = ST_IDLE;
      end
      else if (do_open && state_q == ST_IDLE)
      begin
         state_d = ST_ACTIVE;
      end
      else if ((do_read || do_write) && open_row)
      begin
         // New column command restarts the burst count
         if (do_read)
            state_d = do_auto ? ST_RD_AUTO : ST_READ;
         else
            state_d = do_auto ? ST_WR_AUTO : ST_WRITE;
         cnt_d = burst_len - 4'h1;
         endless_d = (burst_len == 4'h0);
      end
      else if (do_stop && (state_q == ST_READ || state_q == ST_WRITE))
      begin
         state_d = ST_ACTIVE;
      end
      else
      begin
         case (state_q)
            ST_READ, ST_WRITE, ST_RD_AUTO, ST_WR_AUTO:
            begin
               if (!endless_q)
               begin
                  if (cnt_q == 4'h0)
                  begin
                     // Auto-close bursts drop the row when the last beat ends
                     if (state_q == ST_RD_AUTO || state_q == ST_WR_AUTO)
                        state_d = ST_IDLE;
                     else
                        state_d = ST_ACTIVE;
                  end
                  else
                     cnt_d = cnt_q - 4'h1;
               end
            end
            ST_IDLE, ST_ACTIVE:
               state_d = state_q;
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         endless_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         endless_q <= endless_d;
      end
   end

endmodule
`default_nettype wire

// ==== src/stbcd_decoder.v ====
// Purpose: Command decode, bank tracking and clock-enable power control.
// Assumes: Command pins are asynchronous to ref_clk and are synchronised here.
// Notes: All pin-level decisions lag the pins by the two synchroniser stages.
`timescale 1ns/1ps
`default_nettype none
`include "stbcd_map.vh"

// Summary of operation
// - A rise of clock enable ends power-down, self-refresh or suspend at once, with no extra edge.
// - Chip select high deselects; otherwise RAS, CAS and WE pick one of eight commands.
// - A11 picks the bank, activate carries the row address and read or write the column address.
// - Each bank is tracked apart; activate opens an idle bank and precharge closes one or both by A10.
// - Read or write to an open bank starts a burst, A10 adds auto-close, and burst stop returns a plain (not auto-close) burst to the open row.
// - Don't-care pins change nothing, and a deselected cycle starts no command in either bank; running bursts keep counting.
// - Every command, address and control input is sampled on the rising clock edge.
// - Address pins A8 and A9 are not part of the column address.
// - An auto-close burst is its own state and closes the bank when the burst ends.
module stbcd_decoder
(
   input wire ref_clk,
   input wire rst_n,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [11:0] addr,
   output wire [5:0] bank0_state_q,
   output wire [5:0] bank1_state_q,
   output reg [10:0] row_addr0_q,
   output reg [10:0] row_addr1_q,
   output reg [7:0] col_addr_q,
   output reg col_bank_q,
   output reg col_valid_q,
   output reg [11:0] mode_reg_q,
   output reg [3:0] pwr_state_q,
   output reg refresh_q,
   output reg illegal_q
);

   localparam PWR_RUN = `STBCD_PWR_RUN;
   localparam PWR_PDN = `STBCD_PWR_PDN;
   localparam PWR_SREF = `STBCD_PWR_SREF;
   localparam PWR_SUSP = `STBCD_PWR_SUSP;

   // ==================================================
   // Pin synchroniser
   reg [16:0] pin_meta_q;
   reg [16:0] pin_sync_q;
   reg cke_prev_q;
   wire [16:0] pin_raw;

   assign pin_raw = {cke, cs_n, ras_n, cas_n, we_n, addr};

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Idle levels: clock enable low, command pins high
         pin_meta_q <= 17'h0f000;
         pin_sync_q <= 17'h0f000;
         cke_prev_q <= 1'b0;
      end
      else
      begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
         cke_prev_q <= pin_sync_q[16];
      end
   end

   // ==================================================
   // Command decode
   wire cke_now;
   wire sel_n;
   wire [2:0] cmd;
   wire [11:0] a;
   wire sel;
   wire auto;
   wire both_idle;
   wire run_ok;
   wire cmd_ok;
   wire is_stop;
   wire is_read;
   wire is_write;
   wire is_open;
   wire is_close;
   wire is_ref;
   wire is_mode;
   wire open0;
   wire open1;
   wire burst0;
   wire burst1;
   wire tgt_open;
   wire col_cmd;
   wire col_ok;
   wire hold;

   assign cke_now = pin_sync_q[16];
   assign sel_n = pin_sync_q[15];
   assign cmd = pin_sync_q[14:12];
   assign a = pin_sync_q[11:0];
   assign sel = a[`STBCD_BANK_BIT];
   assign auto = a[`STBCD_AUTO_BIT];

   // Clock runs only when enable was high on this and the previous edge
   assign hold = !(cke_prev_q && cke_now);
   assign run_ok = (pwr_state_q == PWR_RUN) && !hold;
   assign cmd_ok = run_ok && !sel_n;

   assign is_stop = cmd_ok && (cmd == `STBCD_CMD_BURST_STOP);
   assign is_read = cmd_ok && (cmd == `STBCD_CMD_READ);
   assign is_write = cmd_ok && (cmd == `STBCD_CMD_WRITE);
   assign is_open = cmd_ok && (cmd == `STBCD_CMD_ROW_OPEN);
   assign is_close = cmd_ok && (cmd == `STBCD_CMD_BANK_CLOSE);
   assign is_ref = cmd_ok && (cmd == `STBCD_CMD_REF);
   assign is_mode = cmd_ok && (cmd == `STBCD_CMD_MODE_SET);

   assign open0 = (bank0_state_q != `STBCD_ST_IDLE);
   assign open1 = (bank1_state_q != `STBCD_ST_IDLE);
   assign burst0 = (bank0_state_q == `STBCD_ST_READ) || (bank0_state_q == `STBCD_ST_WRITE);
   assign burst1 = (bank1_state_q == `STBCD_ST_READ) || (bank1_state_q == `STBCD_ST_WRITE);
   assign both_idle = !open0 && !open1;
   assign tgt_open = sel ? open1 : open0;
   assign col_cmd = is_read || is_write;
   assign col_ok = col_cmd && tgt_open;

   // ==================================================
   // Burst length from the mode register
   reg [3:0] rd_len;
   wire [3:0] wr_len;

   always @*
   begin
      case (mode_reg_q[`STBCD_MR_BL_MSB:0])
         `STBCD_BL_1: rd_len = 4'h1;
         `STBCD_BL_2: rd_len = 4'h2;
         `STBCD_BL_4: rd_len = 4'h4;
         `STBCD_BL_8: rd_len = 4'h8;
         `STBCD_BL_FULL: rd_len = 4'h0;
         default: rd_len = 4'h1;
      endcase
   end

   // Single-write mode ignores burst length for writes
   assign wr_len = mode_reg_q[`STBCD_MR_SINGLE_WR_BIT] ? 4'h1 : rd_len;

   // ==================================================
   // Bank trackers
   // A column command to one bank cuts a plain burst in the other bank
   stbcd_bank u_bank0
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .hold(hold),
      .do_open(is_open && !sel),
      .do_read(is_read && !sel),
      .do_write(is_write && !sel),
      .do_auto(auto),
      .do_stop(is_stop || (col_ok && sel && burst0)),
      .do_close(is_close && (auto || !sel)),
      .burst_len(is_write ? wr_len : rd_len),
      .state_q(bank0_state_q)
   );

   stbcd_bank u_bank1
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .hold(hold),
      .do_open(is_open && sel),
      .do_read(is_read && sel),
      .do_write(is_write && sel),
      .do_auto(auto),
      .do_stop(is_stop || (col_ok && !sel && burst1)),
      .do_close(is_close && (auto || sel)),
      .burst_len(is_write ? wr_len : rd_len),
      .state_q(bank1_state_q)
   );

   // ==================================================
   // Address capture and command reporting
   reg illegal_d;

   always @*
   begin
      illegal_d = 1'b0;
      if (col_cmd && !tgt_open)
         illegal_d = 1'b1;
      if (is_open && tgt_open)
         illegal_d = 1'b1;
      // Refresh or mode set with an open row is flagged, not executed
      if ((is_ref || is_mode) && !both_idle)
         illegal_d = 1'b1;
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_addr0_q <= 11'h000;
         row_addr1_q <= 11'h000;
         col_addr_q <= 8'h00;
         col_bank_q <= 1'b0;
         col_valid_q <= 1'b0;
         mode_reg_q <= `STBCD_MR_RST;
         refresh_q <= 1'b0;
         illegal_q <= 1'b0;
      end
      else
      begin
         col_valid_q <= col_ok;
         refresh_q <= is_ref && both_idle;
         illegal_q <= illegal_d;
         if (is_open && !sel && !open0)
            row_addr0_q <= a[`STBCD_ROW_MSB:0];
         if (is_open && sel && !open1)
            row_addr1_q <= a[`STBCD_ROW_MSB:0];
         if (col_ok)
         begin
            col_addr_q <= a[`STBCD_COL_MSB:0];
            col_bank_q <= sel;
         end
         if (is_mode && both_idle)
            mode_reg_q <= a;
      end
   end

   // ==================================================
   // Power control from clock enable
   reg [3:0] pwr_state_d;

   always @*
   begin
      pwr_state_d = pwr_state_q;
      case (pwr_state_q)
         PWR_RUN:
         begin
            if (cke_prev_q && !cke_now)
            begin
               if (both_idle && !sel_n && cmd == `STBCD_CMD_REF)
                  pwr_state_d = PWR_SREF;
               else if (both_idle)
                  pwr_state_d = PWR_PDN;
               else
                  pwr_state_d = PWR_SUSP;
            end
         end
         PWR_PDN, PWR_SREF, PWR_SUSP:
         begin
            // Leave on the first edge that sees enable high
            if (cke_now)
               pwr_state_d = PWR_RUN;
         end
         default:
            pwr_state_d = PWR_RUN;
      endcase
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwr_state_q <= PWR_RUN;
      else
         pwr_state_q <= pwr_state_d;
   end

endmodule
`default_nettype wire

// ==== src/stbcd_map.vh ====
// Purpose: Shared constants for the two-bank SDRAM command decoder.
// Assumes: Included by its bare name from the design files.
// Notes: Definitions only.
`ifndef STBCD_MAP_VH
`define STBCD_MAP_VH

// ==================================================
// Command codes {ras_n, cas_n, we_n} with cs_n low
`define STBCD_CMD_NOP 3'h7
`define STBCD_CMD_BURST_STOP 3'h6
`define STBCD_CMD_READ 3'h5
`define STBCD_CMD_WRITE 3'h4
`define STBCD_CMD_ROW_OPEN 3'h3
`define STBCD_CMD_BANK_CLOSE 3'h2
`define STBCD_CMD_REF 3'h1
`define STBCD_CMD_MODE_SET 3'h0

// ==================================================
// Bank states, one-hot
`define STBCD_ST_IDLE 6'h01
`define STBCD_ST_ACTIVE 6'h02
`define STBCD_ST_READ 6'h04
`define STBCD_ST_WRITE 6'h08
`define STBCD_ST_RD_AUTO 6'h10
`define STBCD_ST_WR_AUTO 6'h20

// ==================================================
// Power states, one-hot
`define STBCD_PWR_RUN 4'h1
`define STBCD_PWR_PDN 4'h2
`define STBCD_PWR_SREF 4'h4
`define STBCD_PWR_SUSP 4'h8

// ==================================================
// Address pin positions and mode fields
`define STBCD_BANK_BIT 11
`define STBCD_AUTO_BIT 10
`define STBCD_ROW_MSB 10
`define STBCD_COL_MSB 7
`define STBCD_MR_BL_MSB 2
`define STBCD_MR_SINGLE_WR_BIT 9
`define STBCD_MR_RST 12'h000
`define STBCD_BL_1 3'h0
`define STBCD_BL_2 3'h1
`define STBCD_BL_4 3'h2
`define STBCD_BL_8 3'h3
`define STBCD_BL_FULL 3'h7
`define STBCD_BLEN_W 4
`define STBCD_PIN_W 17

`endif

// ==== testbench/stbcd_chk_sva.sv ====
// Purpose: Port-level assertions for the two-bank command decoder.
// Assumes: A pin cycle shows at the outputs three samples later.
// Notes: Bound to stbcd_decoder below.
`timescale 1ns/1ps
`default_nettype none
`include "stbcd_map.vh"
module stbcd_chk_sva
(
   input wire ref_clk,
   input wire rst_n,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [11:0] addr,
   input wire [5:0] bank0_state_q,
   input wire [5:0] bank1_state_q,
   input wire [10:0] row_addr0_q,
   input wire [10:0] row_addr1_q,
   input wire [7:0] col_addr_q,
   input wire col_bank_q,
   input wire col_valid_q,
   input wire [11:0] mode_reg_q,
   input wire [3:0] pwr_state_q,
   input wire refresh_q,
   input wire illegal_q
);
   wire [3:0] cmd_w = {cs_n, ras_n, cas_n, we_n};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Command executes only with clock enable held and power running
   sequence s_go;
      $past(cke, 3) && $past(cke, 4) && $past(pwr_state_q) == `STBCD_PWR_RUN;
   endsequence
   a_deselect_keeps_bank: assert property ($past(cs_n, 3)
      && $past(bank0_state_q) == `STBCD_ST_IDLE
      |-> bank0_state_q == `STBCD_ST_IDLE) else $error("deselect moved bank0");
   a_row_open_bank: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h3 && !$past(addr[11], 3)
      && $past(bank0_state_q) == `STBCD_ST_IDLE) |-> bank0_state_q == `STBCD_ST_ACTIVE
      && row_addr0_q == $past(addr[10:0], 3)) else $error("activate failed");
   a_close_all_banks: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h2 && $past(addr[10], 3))
      |-> bank0_state_q == `STBCD_ST_IDLE && bank1_state_q == `STBCD_ST_IDLE)
      else $error("precharge all failed");
   a_col_capture: assert property (s_go ##0 ($past(cmd_w[3:1], 3) == 3'h2 && !$past(addr[11], 3)
      && $past(bank0_state_q) == `STBCD_ST_ACTIVE) |-> col_valid_q && !col_bank_q
      && col_addr_q == $past(addr[7:0], 3)) else $error("column capture wrong");
   a_read_kind: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h5 && !$past(addr[11], 3)
      && $past(bank0_state_q) == `STBCD_ST_ACTIVE) |-> bank0_state_q == ($past(addr[10], 3)
      ? `STBCD_ST_RD_AUTO : `STBCD_ST_READ)) else $error("read state wrong");
   a_write_kind: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h4 && $past(addr[11], 3)
      && $past(bank1_state_q) == `STBCD_ST_ACTIVE) |-> bank1_state_q == ($past(addr[10], 3)
      ? `STBCD_ST_WR_AUTO : `STBCD_ST_WRITE)) else $error("write state wrong");
   a_stop_reopens_row: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h6
      && $past(bank0_state_q) == `STBCD_ST_READ) |-> bank0_state_q == `STBCD_ST_ACTIVE)
      else $error("burst stop failed");
   a_idle_col_refused: assert property (s_go ##0 ($past(cmd_w[3:1], 3) == 3'h2
      && !$past(addr[11], 3) && $past(bank0_state_q) == `STBCD_ST_IDLE) |-> illegal_q
      && bank0_state_q == `STBCD_ST_IDLE) else $error("idle column accepted");
   a_mode_load: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h0
      && $past(bank0_state_q) == `STBCD_ST_IDLE && $past(bank1_state_q) == `STBCD_ST_IDLE)
      |-> mode_reg_q == $past(addr, 3)) else $error("mode set lost");
   a_refresh_pulse: assert property (s_go ##0 ($past(cmd_w, 3) == 4'h1
      && $past(bank0_state_q) == `STBCD_ST_IDLE && $past(bank1_state_q) == `STBCD_ST_IDLE)
      |-> refresh_q) else $error("refresh missed");
   a_wake_at_once: assert property ($past(pwr_state_q) != `STBCD_PWR_RUN && $past(cke, 3)
      |-> pwr_state_q == `STBCD_PWR_RUN) else $error("wake delayed");
   c_power_down: cover property (pwr_state_q == `STBCD_PWR_PDN);
   c_suspend: cover property (pwr_state_q == `STBCD_PWR_SUSP);
   c_self_refresh: cover property (pwr_state_q == `STBCD_PWR_SREF);
   c_refresh: cover property (refresh_q);
endmodule
bind stbcd_decoder stbcd_chk_sva i_stbcd_chk_sva (.ref_clk(ref_clk), .rst_n(rst_n), .cke(cke),
   .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
   .bank0_state_q(bank0_state_q), .bank1_state_q(bank1_state_q), .row_addr0_q(row_addr0_q),
   .row_addr1_q(row_addr1_q), .col_addr_q(col_addr_q), .col_bank_q(col_bank_q),
   .col_valid_q(col_valid_q), .mode_reg_q(mode_reg_q), .pwr_state_q(pwr_state_q),
   .refresh_q(refresh_q), .illegal_q(illegal_q));
`default_nettype wire

// ==== testbench/stbcd_ctrl_model.sv ====
// Purpose: Memory controller model driving the command pins.
// Assumes: Driven by task calls from the bench.
// Notes: Only defined commands between requests, so suspend is safe.
`timescale 1ns/1ps
`default_nettype none
module stbcd_ctrl_model
(
   input wire ref_clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [11:0] addr
);
   initial
   begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      addr = 12'h000;
   end
   task issue(input logic [3:0] cmd, input logic [11:0] a);
      @(posedge ref_clk);
      #1;
      {cs_n, ras_n, cas_n, we_n} = cmd;
      addr = a;
      @(posedge ref_clk);
      #1;
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      // Inverted so a stale address can never pass as a match
      addr = ~a;
   endtask
   task set_cke(input logic v);
      @(posedge ref_clk);
      #1;
      cke = v;
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the command decoder.
// Assumes: Burst length four unless a scenario sets full page.
// Notes: Each command is judged two edges after its pin cycle.
`timescale 1ns/1ps
`default_nettype none
`include "stbcd_map.vh"
module tb_top;
   logic ref_clk;
   logic rst_n;
   wire cke, cs_n, ras_n, cas_n, we_n, col_bank, col_valid, refr, illeg;
   wire [11:0] addr, mode;
   wire [5:0] b0, b1;
   wire [10:0] row0, row1;
   wire [7:0] col;
   wire [3:0] pwr;
   int errors, tests_run, cyc;
   stbcd_ctrl_model i_stbcd_ctrl_model (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr));
   stbcd_decoder i_stbcd_decoder (.ref_clk(ref_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank0_state_q(b0),
      .bank1_state_q(b1), .row_addr0_q(row0), .row_addr1_q(row1), .col_addr_q(col),
      .col_bank_q(col_bank), .col_valid_q(col_valid), .mode_reg_q(mode),
      .pwr_state_q(pwr), .refresh_q(refr), .illegal_q(illeg));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task end_sim;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         end_sim();
      end
   end
   task chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task cmd(input logic [2:0] c, input logic [11:0] a);
      i_stbcd_ctrl_model.issue({1'b0, c}, a);
      wait_n(2);
   endtask
   task t_read;
      cmd(`STBCD_CMD_MODE_SET, 12'h002);
      chk(mode, 12'h002);
      cmd(`STBCD_CMD_ROW_OPEN, 12'h5a5);
      chk(12'(b0), 12'(`STBCD_ST_ACTIVE));
      chk(12'(row0), 12'h5a5);
      chk(12'(b1), 12'(`STBCD_ST_IDLE));
      cmd(`STBCD_CMD_READ, 12'h33c);
      chk(12'(b0), 12'(`STBCD_ST_READ));
      chk(12'({col_valid, col}), 12'h13c);
      wait_n(3);
      chk(12'(b0), 12'(`STBCD_ST_READ));
      wait_n(1);
      chk(12'(b0), 12'(`STBCD_ST_ACTIVE));
   endtask
   task t_auto_close;
      cmd(`STBCD_CMD_ROW_OPEN, 12'h801);
      cmd(`STBCD_CMD_WRITE, 12'hc12);
      chk(12'(b1), 12'(`STBCD_ST_WR_AUTO));
      chk(12'(col_bank), 12'h001);
      wait_n(4);
      chk(12'(b1), 12'(`STBCD_ST_IDLE));
      cmd(`STBCD_CMD_ROW_OPEN, 12'h802);
      chk(12'(row1), 12'h002);
      cmd(`STBCD_CMD_BANK_CLOSE, 12'h800);
      chk({b0, b1}, {`STBCD_ST_ACTIVE, `STBCD_ST_IDLE});
      cmd(`STBCD_CMD_BANK_CLOSE, 12'h400);
      chk(12'(b0), 12'(`STBCD_ST_IDLE));
   endtask
   task t_stop;
      cmd(`STBCD_CMD_MODE_SET, 12'h007);
      cmd(`STBCD_CMD_ROW_OPEN, 12'h000);
      cmd(`STBCD_CMD_READ, 12'h000);
      wait_n(8);
      chk(12'(b0), 12'(`STBCD_ST_READ));
      cmd(`STBCD_CMD_BURST_STOP, 12'h000);
      chk({b0, b1}, {`STBCD_ST_ACTIVE, `STBCD_ST_IDLE});
      i_stbcd_ctrl_model.issue(4'ha, 12'h400);
      wait_n(3);
      chk(12'(b0), 12'(`STBCD_ST_ACTIVE));
      cmd(`STBCD_CMD_BANK_CLOSE, 12'h400);
      cmd(`STBCD_CMD_MODE_SET, 12'h002);
   endtask
   task t_refuse;
      cmd(`STBCD_CMD_READ, 12'h000);
      chk(12'({illeg, b0}), 12'(1 << 6 | `STBCD_ST_IDLE));
      cmd(`STBCD_CMD_REF, 12'h000);
      chk(12'({refr, b0}), 12'(1 << 6 | `STBCD_ST_IDLE));
   endtask
   task t_power;
      i_stbcd_ctrl_model.set_cke(1'b0);
      wait_n(4);
      chk(12'(pwr), 12'(`STBCD_PWR_PDN));
      cmd(`STBCD_CMD_ROW_OPEN, 12'h000);
      chk(12'(b0), 12'(`STBCD_ST_IDLE));
      i_stbcd_ctrl_model.set_cke(1'b1);
      wait_n(4);
      chk(12'(pwr), 12'(`STBCD_PWR_RUN));
      cmd(`STBCD_CMD_ROW_OPEN, 12'h000);
      chk(12'(b0), 12'(`STBCD_ST_ACTIVE));
      i_stbcd_ctrl_model.set_cke(1'b0);
      wait_n(4);
      chk(12'(pwr), 12'(`STBCD_PWR_SUSP));
      i_stbcd_ctrl_model.set_cke(1'b1);
      wait_n(4);
      chk(12'(pwr), 12'(`STBCD_PWR_RUN));
      cmd(`STBCD_CMD_BANK_CLOSE, 12'h400);
      // Refresh on the very cycle that drops clock enable
      fork
         i_stbcd_ctrl_model.issue({1'b0, `STBCD_CMD_REF}, 12'h000);
         i_stbcd_ctrl_model.set_cke(1'b0);
      join
      wait_n(2);
      chk(12'(pwr), 12'(`STBCD_PWR_SREF));
      i_stbcd_ctrl_model.set_cke(1'b1);
      wait_n(4);
      chk(12'(pwr), 12'(`STBCD_PWR_RUN));
   endtask
   initial
   begin
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      wait_n(4);
      t_read();
      t_auto_close();
      t_stop();
      t_refuse();
      t_power();
      end_sim();
   end
endmodule
`default_nettype wire
